// ---- logic/curve_engine_operand_setup.sv ----
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// [RULE1] Config bits 12:8 locate operand B
// [RULE2] Config bits 4:0 locate operand A
// [RULE3] Config bits 20:16 locate the result
// [RULE4] Recalc bit forces R mod N computation
// [RULE5] Engine clears recalc; writing zero ignored
// [RULE6] Software sets recalc after new modulus
// [RULE7] Command bit 30 is coefficient B sign
// [RULE8] Command bit 29 is coefficient A sign
// [RULE9] Command bits 15:8 give length in dwords
// [RULE10] Software keeps length within maximum space
// [RULE11] Code 0x02 selects 128-bit generic operands
// [RULE12] Prime field: 0x03 192-bit, 0x04 256-bit
// [RULE13] Binary field: 0x03 192-bit, 0x04 256-bit
// [RULE14] Command bit 7 selects prime or binary
// [RULE15] Reserved bits read zero; fields reset zero
module curve_engine_operand_setup #(
	parameter int MAX_OPERAND_SPACE_PARAM = curve_setup_pkg::MAX_SPACE_LOG2
) (
	input  wire logic                             clk_i,
	input  wire logic                             rst_i,
	input  wire logic                             wb_cyc_i,
	input  wire logic                             wb_stb_i,
	input  wire logic                             wb_we_i,
	input  wire logic [31:0]                      wb_adr_i,
	input  wire logic [3:0]                       wb_sel_i,
	input  wire logic [31:0]                      wb_dat_i,
	output logic      [31:0]                      wb_dat_o,
	output logic                                  wb_ack_o,
	input  wire logic                             op_start_i,
	input  wire logic                             recalc_done_i,
	output curve_setup_pkg::engine_setup_type     setup_o,
	output logic                                  recalc_request_o,
	output logic                                  recalc_with_op_o,
	output curve_setup_pkg::profile_type          profile_o,
	output logic [curve_setup_pkg::BITS_W-1:0]    operand_bits_o,
	output logic                                  length_ok_o
);
	import curve_setup_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Declarations
	logic        take;
	logic        wr_stb;
	logic        rd_stb;
	logic        hit_pointers;
	logic        hit_command;
	logic [31:0] lane_mask;
	logic [31:0] pointers_r;
	logic [31:0] pointers_nxt;
	logic [31:0] command_r;
	logic [31:0] command_nxt;
	logic [31:0] read_value;
	logic [31:0] dat_r;
	logic        recalc_set;
	logic        recalc_pending;
	logic        recalc_with_op;
	profile_type profile_r;
	profile_type profile_nxt;
	logic [BITS_W-1:0] bits_r;
	logic [BITS_W-1:0] bits_nxt;
	logic        length_ok_r;
	logic        length_ok_nxt;
	logic [LEN_W-1:0] cur_length;
	field_type   cur_field;

	////////////////////////////////////////////////////////////////////////////
	// Bus handshake: ack follows a take by one cycle
	wb_classic_port u_port (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.cyc_i  (wb_cyc_i),
		.stb_i  (wb_stb_i),
		.take_o (take),
		.ack_o  (wb_ack_o)
	);

	// Address decode; unmapped addresses still ack and read zero
	assign hit_pointers = (wb_adr_i == POINTERS_ADDR);
	assign hit_command  = (wb_adr_i == COMMAND_ADDR);
	assign wr_stb       = take && wb_we_i;
	assign rd_stb       = take && !wb_we_i;

	// One byte-lane mask bit group per select line
	genvar lane;
	generate
		for (lane = 0; lane < 4; lane++) begin : g_lane
			assign lane_mask[lane*8 +: 8] = {8{wb_sel_i[lane]}};
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Pointer register: merge selected lanes, reserved bits forced to zero
	always_comb begin
		pointers_nxt = pointers_r;
		if (wr_stb && hit_pointers) begin
			pointers_nxt = ((pointers_r & ~lane_mask) | (wb_dat_i & lane_mask))
				& POINTERS_MASK; // [RULE15]
		end
	end

	// Pointer storage feeding the engine fetch and store ports
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pointers_r <= POINTERS_RESET; // [RULE15]
		end else begin
			pointers_r <= pointers_nxt; // [RULE1] [RULE2] [RULE3]
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Command register; the recalc bit lives in the tracker, not here
	always_comb begin
		command_nxt = command_r;
		if (wr_stb && hit_command) begin
			command_nxt = ((command_r & ~lane_mask) | (wb_dat_i & lane_mask))
				& COMMAND_MASK; // [RULE15]
		end
	end

	// Signs, length and field held for the engine
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			command_r <= COMMAND_RESET; // [RULE15]
		end else begin
			command_r <= command_nxt; // [RULE7] [RULE8] [RULE9] [RULE14]
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Recalc request: only a written one counts; a zero does nothing
	// Software raises it after loading a new modulus [RULE6]
	assign recalc_set = wr_stb && hit_command && wb_sel_i[3]
		&& wb_dat_i[RECALC_BIT]; // [RULE4] [RULE5]

	recalc_tracker u_recalc (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.set_i      (recalc_set),
		.op_start_i (op_start_i),
		.done_i     (recalc_done_i),
		.pending_o  (recalc_pending),
		.with_op_o  (recalc_with_op)
	);

	assign recalc_request_o = recalc_pending; // [RULE4]
	assign recalc_with_op_o = recalc_with_op;

	////////////////////////////////////////////////////////////////////////////
	// Setup fields handed to the datapath
	assign setup_o.operand_a_pointer = pointers_r[PTR_A_LSB +: PTR_W]; // [RULE2]
	assign setup_o.operand_b_pointer = pointers_r[PTR_B_LSB +: PTR_W]; // [RULE1]
	assign setup_o.result_pointer    = pointers_r[RESULT_LSB +: PTR_W]; // [RULE3]
	assign setup_o.operand_length    = command_r[LEN_LSB +: LEN_W]; // [RULE9]
	assign setup_o.field             = field_type'(command_r[FIELD_BIT]); // [RULE14]
	assign setup_o.coeff_a_sign      = command_r[SIGN_A_BIT]; // [RULE8]
	assign setup_o.coeff_b_sign      = command_r[SIGN_B_BIT]; // [RULE7]

	assign cur_length = command_r[LEN_LSB +: LEN_W];
	assign cur_field  = field_type'(command_r[FIELD_BIT]);

	////////////////////////////////////////////////////////////////////////////
	// Length decode; registered so the datapath sees a clean, glitch-free code
	always_comb begin
		profile_nxt = PROF_CUSTOM;
		case (cur_length)
			LEN_128: begin
				profile_nxt = PROF_GENERIC_128; // [RULE11]
			end
			LEN_192: begin
				profile_nxt = (cur_field == FIELD_BINARY) ? PROF_BINARY_192
					: PROF_PRIME_192; // [RULE12] [RULE13]
			end
			LEN_256: begin
				profile_nxt = (cur_field == FIELD_BINARY) ? PROF_BINARY_256
					: PROF_PRIME_256; // [RULE12] [RULE13]
			end
			default: begin
				profile_nxt = PROF_CUSTOM;
			end
		endcase
	end

	// Width in bits and a limit check; the limit is only advisory
	always_comb begin
		bits_nxt      = BITS_W'({6'h00, cur_length} << DWORD_SHIFT); // [RULE9]
		length_ok_nxt = (cur_length != 8'h00)
			&& (32'(bits_nxt) <= (32'h1 << MAX_OPERAND_SPACE_PARAM)); // [RULE10]
	end

	// Decoded length outputs
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			profile_r   <= PROF_CUSTOM;
			bits_r      <= '0;
			length_ok_r <= 1'b0;
		end else begin
			profile_r   <= profile_nxt;
			bits_r      <= bits_nxt;
			length_ok_r <= length_ok_nxt;
		end
	end

	assign profile_o      = profile_r;
	assign operand_bits_o = bits_r;
	assign length_ok_o    = length_ok_r;

	////////////////////////////////////////////////////////////////////////////
	// Read path; bit 31 shows the live recalc request
	always_comb begin
		read_value = 32'h0000_0000;
		if (hit_pointers) begin
			read_value = pointers_r & POINTERS_MASK; // [RULE15]
		end else if (hit_command) begin
			read_value = (command_r & COMMAND_MASK)
				| ({31'h0, recalc_pending} << RECALC_BIT); // [RULE5]
		end
	end

	// Read data captured at the take, held for the ack cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_r <= 32'h0000_0000;
		end else if (rd_stb) begin
			dat_r <= read_value;
		end else if (take) begin
			dat_r <= 32'h0000_0000;
		end
	end

	assign wb_dat_o = dat_r;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence ptr_write_s;
		wr_stb && hit_pointers;
	endsequence

	sequence cmd_write_s;
		wr_stb && hit_command;
	endsequence

	sequence recalc_finish_s;
		recalc_done_i && !recalc_set && recalc_pending;
	endsequence

	ptr_b_write_a: assert property (ptr_write_s ##0 wb_sel_i[1] |=> // [RULE1]
		setup_o.operand_b_pointer == $past(wb_dat_i[PTR_B_LSB +: PTR_W]))
		else $error("operand B pointer not taken");

	ptr_a_write_a: assert property (ptr_write_s ##0 wb_sel_i[0] |=> // [RULE2]
		setup_o.operand_a_pointer == $past(wb_dat_i[PTR_A_LSB +: PTR_W]))
		else $error("operand A pointer not taken");

	result_ptr_a: assert property (ptr_write_s ##0 wb_sel_i[2] |=> // [RULE3]
		setup_o.result_pointer == $past(wb_dat_i[RESULT_LSB +: PTR_W]))
		else $error("result pointer not taken");

	recalc_raise_a: assert property (recalc_set |=> recalc_request_o) // [RULE4]
		else $error("recalc request not raised");

	recalc_op_a: assert property ( // [RULE4]
		recalc_request_o && !recalc_with_op_o && op_start_i && !recalc_done_i
		|=> recalc_with_op_o && recalc_request_o)
		else $error("operation started without recalc");

	recalc_clear_a: assert property (recalc_finish_s |=> // [RULE5]
		!recalc_request_o ##1 (recalc_request_o == $past(recalc_set)))
		else $error("recalc request not cleared");

	recalc_zero_a: assert property ( // [RULE5]
		cmd_write_s ##0 !wb_dat_i[RECALC_BIT] && recalc_request_o
		&& !recalc_done_i |=> recalc_request_o)
		else $error("zero write cleared recalc");

	sign_b_a: assert property (cmd_write_s ##0 wb_sel_i[3] |=> // [RULE7]
		setup_o.coeff_b_sign == $past(wb_dat_i[SIGN_B_BIT]))
		else $error("coefficient B sign wrong");

	sign_a_a: assert property (cmd_write_s ##0 wb_sel_i[3] |=> // [RULE8]
		setup_o.coeff_a_sign == $past(wb_dat_i[SIGN_A_BIT]))
		else $error("coefficient A sign wrong");

	length_field_a: assert property (cmd_write_s ##0 wb_sel_i[1] |=> // [RULE9]
		setup_o.operand_length == $past(wb_dat_i[LEN_LSB +: LEN_W])
		##1 operand_bits_o == BITS_W'({6'h00, $past(setup_o.operand_length)} << 6))
		else $error("operand length wrong");

	generic_len_a: assert property ( // [RULE11]
		$past(cur_length) == LEN_128 |-> profile_o == PROF_GENERIC_128)
		else $error("128-bit code not decoded");

	prime_prof_a: assert property ( // [RULE12]
		$past(cur_field) == FIELD_PRIME && $past(cur_length) == LEN_192
		|-> profile_o == PROF_PRIME_192)
		else $error("prime 192 not decoded");

	binary_prof_a: assert property ( // [RULE13]
		$past(cur_field) == FIELD_BINARY && $past(cur_length) == LEN_256
		|-> profile_o == PROF_BINARY_256)
		else $error("binary 256 not decoded");

	field_sel_a: assert property (cmd_write_s ##0 wb_sel_i[0] |=> // [RULE14]
		setup_o.field == field_type'($past(wb_dat_i[FIELD_BIT])))
		else $error("field select wrong");

	reserved_rd_a: assert property ( // [RULE15]
		rd_stb && hit_pointers |=> wb_ack_o && (wb_dat_o & ~POINTERS_MASK) == 32'h0)
		else $error("reserved bits read nonzero");

	reset_zero_a: assert property ($past(rst_i) |-> // [RULE15]
		setup_o == '0 && !recalc_request_o)
		else $error("fields not zero after reset");

	recalc_hold_a: assert property ( // [RULE4]
		recalc_request_o && !recalc_done_i |=> recalc_request_o)
		else $error("recalc request dropped early");

	set_wins_a: assert property ( // [RULE5]
		recalc_set && recalc_done_i |=> recalc_request_o && !recalc_with_op_o)
		else $error("recalc set lost at completion");

	op_done_a: assert property ( // [RULE5]
		recalc_with_op_o && recalc_done_i && !recalc_set
		|=> !recalc_with_op_o && !recalc_request_o)
		else $error("recalc not cleared after operation");

	prime_256_a: assert property ( // [RULE12]
		$past(cur_field) == FIELD_PRIME && $past(cur_length) == LEN_256
		|-> profile_o == PROF_PRIME_256)
		else $error("prime 256 not decoded");

	binary_192_a: assert property ( // [RULE13]
		$past(cur_field) == FIELD_BINARY && $past(cur_length) == LEN_192
		|-> profile_o == PROF_BINARY_192)
		else $error("binary 192 not decoded");

	cmd_reserved_a: assert property ( // [RULE15]
		rd_stb && hit_command |=> wb_ack_o
		&& (wb_dat_o & ~(COMMAND_MASK | (32'h0000_0001 << RECALC_BIT))) == 32'h0000_0000)
		else $error("reserved command bits read nonzero");

	recalc_read_a: assert property ( // [RULE5]
		rd_stb && hit_command |=> wb_dat_o[RECALC_BIT] == $past(recalc_pending))
		else $error("recalc bit read back wrong");

endmodule
`default_nettype wire

// ---- common/curve_setup_pkg.sv ----
`default_nettype none
package curve_setup_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Register byte addresses on the peripheral bus
	localparam logic [31:0] POINTERS_ADDR = 32'h5000_6000;
	localparam logic [31:0] COMMAND_ADDR  = 32'h5000_6004;

	////////////////////////////////////////////////////////////////////////////
	// Field positions and widths
	localparam int PTR_W        = 5;
	localparam int PTR_A_LSB    = 0;
	localparam int PTR_B_LSB    = 8;
	localparam int RESULT_LSB   = 16;
	localparam int LEN_W        = 8;
	localparam int LEN_LSB      = 8;
	localparam int FIELD_BIT    = 7;
	localparam int SIGN_A_BIT   = 29;
	localparam int SIGN_B_BIT   = 30;
	localparam int RECALC_BIT   = 31;
	localparam int BITS_W       = 14;

	// Writable bits; the rest are reserved and read zero, except command bit 31, which reads the recalc request
	localparam logic [31:0] POINTERS_MASK = 32'h001f_1f1f;
	localparam logic [31:0] COMMAND_MASK  = 32'h6000_ff80;

	////////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [31:0] POINTERS_RESET = 32'h0000_0000;
	localparam logic [31:0] COMMAND_RESET  = 32'h0000_0000;

	////////////////////////////////////////////////////////////////////////////
	// Operand length codes, in 64-bit double words
	localparam int          DWORD_SHIFT = 6;
	localparam logic [7:0]  LEN_128     = 8'h02;
	localparam logic [7:0]  LEN_192     = 8'h03;
	localparam logic [7:0]  LEN_256     = 8'h04;

	// Default log2 of the largest operand space in bits
	localparam int MAX_SPACE_LOG2 = 12;

	////////////////////////////////////////////////////////////////////////////
	// Types
	typedef enum logic {
		FIELD_PRIME  = 1'b0,
		FIELD_BINARY = 1'b1
	} field_type;

	typedef enum logic [2:0] {
		PROF_CUSTOM      = 3'h0,
		PROF_GENERIC_128 = 3'h1,
		PROF_PRIME_192   = 3'h2,
		PROF_PRIME_256   = 3'h3,
		PROF_BINARY_192  = 3'h4,
		PROF_BINARY_256  = 3'h5
	} profile_type;

	typedef enum logic [1:0] {
		RC_IDLE    = 2'b00,
		RC_PENDING = 2'b01,
		RC_ACTIVE  = 2'b11
	} recalc_state_type;

	typedef struct packed {
		logic [PTR_W-1:0] operand_a_pointer;
		logic [PTR_W-1:0] operand_b_pointer;
		logic [PTR_W-1:0] result_pointer;
		logic [LEN_W-1:0] operand_length;
		field_type        field;
		logic             coeff_a_sign;
		logic             coeff_b_sign;
	} engine_setup_type;

endpackage
`default_nettype wire

// ---- logic/wb_classic_port.sv ----
`timescale 1ns/1ps
`default_nettype none
module wb_classic_port (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic cyc_i,
	input  wire logic stb_i,
	output logic      take_o,
	output logic      ack_o
);
	logic ack_r;

	// New request only when no ack is standing, so each cycle answers once
	assign take_o = cyc_i && stb_i && !ack_r;
	assign ack_o  = ack_r;

	////////////////////////////////////////////////////////////////////////////
	// Ack one cycle after the take, dropped in the following cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= take_o;
		end
	end
endmodule
`default_nettype wire

// ---- logic/recalc_tracker.sv ----
`timescale 1ns/1ps
`default_nettype none
module recalc_tracker
	import curve_setup_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       set_i,
	input  wire logic       op_start_i,
	input  wire logic       done_i,
	output logic            pending_o,
	output logic            with_op_o
);
	recalc_state_type state_r;
	recalc_state_type state_nxt;

	////////////////////////////////////////////////////////////////////////////
	// A set in the same cycle as done wins, so no new request is lost
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			RC_IDLE: begin
				if (set_i) begin
					state_nxt = RC_PENDING;
				end
			end
			RC_PENDING: begin
				if (done_i) begin
					state_nxt = set_i ? RC_PENDING : RC_IDLE; // [RULE5]
				end else if (op_start_i) begin
					state_nxt = RC_ACTIVE; // [RULE4]
				end
			end
			RC_ACTIVE: begin
				if (done_i) begin
					state_nxt = set_i ? RC_PENDING : RC_IDLE; // [RULE5]
				end
			end
			default: begin
				state_nxt = RC_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= RC_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign pending_o = (state_r != RC_IDLE);
	assign with_op_o = (state_r == RC_ACTIVE);
endmodule
`default_nettype wire

// ---- bench/test_curve_engine_operand_setup.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_curve_engine_operand_setup;
	import curve_setup_pkg::*;

	localparam int          SPACE_LOG2    = 12;
	localparam logic [31:0] UNMAPPED_ADDR = 32'h5000_6008;

	logic             clk_i;
	logic             rst_i;
	logic             cyc;
	logic             stb;
	logic             we;
	logic [31:0]      adr;
	logic [3:0]       sel;
	logic [31:0]      wdat;
	logic [31:0]      rdat;
	logic             ack;
	logic             op_start;
	logic             recalc_done;
	engine_setup_type setup;
	logic             recalc_req;
	logic             with_op;
	profile_type      profile;
	logic [13:0]      op_bits;
	logic             len_ok;
	logic [31:0]      rd_val;
	int               error_cnt;
	int               total_checks;

	curve_engine_operand_setup #(
		.MAX_OPERAND_SPACE_PARAM(SPACE_LOG2)
	) curve_engine_operand_setup_inst (
		.clk_i           (clk_i),
		.rst_i           (rst_i),
		.wb_cyc_i        (cyc),
		.wb_stb_i        (stb),
		.wb_we_i         (we),
		.wb_adr_i        (adr),
		.wb_sel_i        (sel),
		.wb_dat_i        (wdat),
		.wb_dat_o        (rdat),
		.wb_ack_o        (ack),
		.op_start_i      (op_start),
		.recalc_done_i   (recalc_done),
		.setup_o         (setup),
		.recalc_request_o(recalc_req),
		.recalc_with_op_o(with_op),
		.profile_o       (profile),
		.operand_bits_o  (op_bits),
		.length_ok_o     (len_ok)
	);

	////////////////////////////////////////////////////////////////////////////
	// 100 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	////////////////////////////////////////////////////////////////////////////
	// Verdict and comparison helpers
	task automatic finish_test();
		$display("checks %0d, mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] expected);
		total_checks++;
		if (seen !== expected) begin
			error_cnt++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, expected);
		end
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Classic Wishbone cycle; request held until ack is sampled high
	task automatic wb_cycle(input logic write, input logic [31:0] addr,
			input logic [3:0] lanes, input logic [31:0] data, output logic [31:0] rd);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= write;
		adr  <= addr;
		sel  <= lanes;
		wdat <= data;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 20);
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we  <= 1'b0;
		// A missing ack ends the run through the common report
		if (ack !== 1'b1) begin
			error_cnt++;
			finish_test();
		end
	endtask

	task automatic wr(input logic [31:0] addr, input logic [31:0] data);
		logic [31:0] unused;
		wb_cycle(1'b1, addr, 4'hf, data, unused);
	endtask

	task automatic rd_chk(input logic [31:0] addr, input logic [31:0] expected);
		wb_cycle(1'b0, addr, 4'hf, 32'h0000_0000, rd_val);
		check(rd_val, expected);
	endtask

	// Decoded outputs trail the registers by a cycle, so let two edges pass
	task automatic settle();
		repeat (2) @(posedge clk_i);
	endtask

	// One-cycle engine event: 0 start of operation, 1 recalculation finished
	task automatic pulse(input logic done);
		@(posedge clk_i);
		op_start    <= ~done;
		recalc_done <= done;
		@(posedge clk_i);
		op_start    <= 1'b0;
		recalc_done <= 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Hang guard, 50000 cycles, far beyond the length of the run
	initial begin
		#500000;
		error_cnt++;
		finish_test();
	end

	////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		logic [7:0]  codes [9];
		profile_type exp_prof;
		codes = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h40, 8'h41, 8'hff};
		error_cnt    = 0;
		total_checks = 0;
		rst_i        = 1'b1;
		cyc          = 1'b0;
		stb          = 1'b0;
		we           = 1'b0;
		adr          = 32'h0000_0000;
		sel          = 4'h0;
		wdat         = 32'h0000_0000;
		op_start     = 1'b0;
		recalc_done  = 1'b0;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		check(32'(setup), 32'h0000_0000);
		rd_chk(POINTERS_ADDR, POINTERS_RESET);
		rd_chk(COMMAND_ADDR, COMMAND_RESET);
		// Pointer fields, reserved gaps and byte lanes
		wr(POINTERS_ADDR, 32'hffff_ffff);
		rd_chk(POINTERS_ADDR, 32'h001f_1f1f);
		wr(POINTERS_ADDR, 32'h0015_0a03);
		settle();
		check(32'(setup.operand_a_pointer), 32'h0000_0003);
		check(32'(setup.operand_b_pointer), 32'h0000_000a);
		check(32'(setup.result_pointer), 32'h0000_0015);
		wb_cycle(1'b1, POINTERS_ADDR, 4'b0010, 32'hffff_11ff, rd_val);
		rd_chk(POINTERS_ADDR, 32'h0015_1103);
		// Unmapped place is acked but holds nothing
		wr(UNMAPPED_ADDR, 32'hffff_ffff);
		rd_chk(UNMAPPED_ADDR, 32'h0000_0000);
		rd_chk(POINTERS_ADDR, 32'h0015_1103);
		// Coefficient signs and reserved command bits
		wr(COMMAND_ADDR, 32'h4000_0000);
		settle();
		check(32'({setup.coeff_b_sign, setup.coeff_a_sign}), 32'h0000_0002);
		wr(COMMAND_ADDR, 32'h2000_0000);
		settle();
		check(32'({setup.coeff_b_sign, setup.coeff_a_sign}), 32'h0000_0001);
		wr(COMMAND_ADDR, 32'h1fff_007f);
		rd_chk(COMMAND_ADDR, 32'h0000_0000);
		// Nine length codes in both fields, including the size limit edges
		for (int f = 0; f < 2; f++) begin
			foreach (codes[i]) begin
				wr(COMMAND_ADDR, {16'h0000, codes[i], f[0], 7'h00});
				settle();
				case (codes[i])
					LEN_128: exp_prof = PROF_GENERIC_128;
					LEN_192: exp_prof = (f == 1) ? PROF_BINARY_192 : PROF_PRIME_192;
					LEN_256: exp_prof = (f == 1) ? PROF_BINARY_256 : PROF_PRIME_256;
					default: exp_prof = PROF_CUSTOM;
				endcase
				check(32'(profile), 32'(exp_prof));
				check(32'(setup.field), f);
				check(32'(setup.operand_length), 32'(codes[i]));
				check(32'(op_bits), 32'(codes[i]) << DWORD_SHIFT);
				check(32'(len_ok), 32'(codes[i] != 8'h00 &&
					(32'(codes[i]) << DWORD_SHIFT) <= (32'h1 << SPACE_LOG2)));
			end
		end
		// Recalculation request carried by the next operation
		wr(COMMAND_ADDR, 32'h8000_0000);
		settle();
		check(32'(recalc_req), 32'h0000_0001);
		wr(COMMAND_ADDR, 32'h0000_0000);
		rd_chk(COMMAND_ADDR, 32'h8000_0000);
		check(32'(with_op), 32'h0000_0000);
		pulse(1'b0);
		settle();
		check(32'({recalc_req, with_op}), 32'h0000_0003);
		pulse(1'b1);
		settle();
		check(32'({recalc_req, with_op}), 32'h0000_0000);
		rd_chk(COMMAND_ADDR, 32'h0000_0000);
		// Early completion clears; a start with nothing pending is ignored
		wr(COMMAND_ADDR, 32'h8000_0000);
		pulse(1'b1);
		settle();
		check(32'(recalc_req), 32'h0000_0000);
		pulse(1'b0);
		settle();
		check(32'(with_op), 32'h0000_0000);
		// A new request in the completion cycle survives it
		wr(COMMAND_ADDR, 32'h8000_0000);
		pulse(1'b0);
		fork
			wr(COMMAND_ADDR, 32'h8000_0000);
			pulse(1'b1);
		join
		settle();
		check(32'({recalc_req, with_op}), 32'h0000_0002);
		// Second reset in mid-run clears every field
		wr(POINTERS_ADDR, 32'h0015_1103);
		wr(COMMAND_ADDR, 32'he000_ff80);
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		settle();
		check(32'(setup), 32'h0000_0000);
		check(32'({recalc_req, with_op, len_ok}), 32'h0000_0000);
		rd_chk(COMMAND_ADDR, 32'h0000_0000);
		finish_test();
	end

endmodule
`default_nettype wire
